// File: core/fc_pkg.sv
// Shared constants and types for the four-way cache controller.
// Assumes one 100 MHz clock and an APB3 register bus.
package fc_pkg;
   // Printed offset is not word aligned, so it is kept as a register index
   localparam logic [31:0] CTRL_IDX      = 32'hfffffe92;
   localparam logic [31:0] CTRL_ADDR     = {CTRL_IDX[29:0], 2'b00};
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam int          CTRL_WAY_LO   = 6;
   localparam int          CTRL_WB       = 5;
   localparam int          CTRL_PURGE    = 4;
   localparam int          CTRL_TWO_WAY  = 3;
   localparam int          CTRL_D_INH    = 2;
   localparam int          CTRL_I_INH    = 1;
   localparam int          CTRL_EN       = 0;
   // Address partitions, address bits 31..29
   localparam logic [2:0]  AREA_CACHED   = 3'h0;
   localparam logic [2:0]  AREA_THRU     = 3'h1;
   localparam logic [2:0]  AREA_APURGE   = 3'h2;
   localparam logic [2:0]  AREA_ADDRARR  = 3'h3;
   localparam logic [2:0]  AREA_DATAARR  = 3'h6;
   localparam logic [2:0]  AREA_IO       = 3'h7;
   // Address array direct access word layout
   localparam int          AA_VALID      = 2;
   localparam int          AA_DIRTY      = 1;
   localparam int          TAG_LO        = 10;
   localparam int          TAG_W         = 19;
   localparam int          IDX_LO        = 4;
   localparam int          WAY_LO        = 10;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_LOOK  = 3'b001,
      S_WBACK = 3'b010,
      S_FILL  = 3'b011,
      S_THRU  = 3'b100,
      S_PURGE = 3'b101
   } fc_state_t;
endpackage

// File: core/fc_lru_if.sv
// Carries one entry's replacement history between the controller and the
// pseudo-LRU engine. Purely combinational, same clock domain.
interface fc_lru_if;
   logic [2:0] lruState;
   logic [1:0] usedWay;
   logic       twoWay;
   logic [1:0] victim;
   logic [2:0] touched;
   modport user   (output lruState, output usedWay, output twoWay,
                   input victim, input touched);
   modport engine (input lruState, input usedWay, input twoWay,
                   output victim, output touched);
endinterface

// File: core/fc_plru.sv
// Tree pseudo-LRU: bit0 picks a pair, bit1 picks in ways 0/1, bit2 in 2/3.
// Assumes the caller stores the touched state back after each access.
module fc_plru (
   // Replacement history port
   fc_lru_if.engine lru
);
   always_comb begin
      // Two-way mode only ever replaces ways 2 and 3
      if (lru.twoWay || lru.lruState[0])
         lru.victim = {1'b1, lru.lruState[2]};
      else
         lru.victim = {1'b0, lru.lruState[1]};
      lru.touched = lru.lruState;
      lru.touched[0] = ~lru.usedWay[1];
      if (lru.usedWay[1])
         lru.touched[2] = ~lru.usedWay[0];
      else
         lru.touched[1] = ~lru.usedWay[0];
   end
endmodule

// File: core/fc_cache_ctrl.sv
// Four-way set-associative cache controller with its control register.
// Assumes CPU and memory handshakes come from logic on mclk, held until
// answered; the control register is reached over APB3.
module fc_cache_ctrl #(
   parameter int WAYS    = 4,
   parameter int ENTRIES = 64,
   parameter int WORDS   = 4
) (
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // APB register slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // CPU side
   input  wire logic        cpuReq,
   input  wire logic        cpuWr,
   input  wire logic        cpuFetch,
   input  wire logic [31:0] cpuAddr,
   input  wire logic [31:0] cpuWdata,
   input  wire logic [3:0]  cpuStrb,
   output logic      [31:0] cpuRdata,
   output logic             cpuReady,
   // Internal bus toward external memory
   output logic             memReq,
   output logic             memWr,
   output logic      [31:0] memAddr,
   output logic      [31:0] memWdata,
   output logic      [3:0]  memStrb,
   input  wire logic [31:0] memRdata,
   input  wire logic        memAck
);
   localparam int TW = fc_pkg::TAG_W;

   // Arrays
   logic [TW-1:0] tagMem   [WAYS][ENTRIES];
   logic          validMem [WAYS][ENTRIES];
   logic          dirtyMem [WAYS][ENTRIES];
   logic [2:0]    lruMem   [ENTRIES];
   logic [31:0]   dataMem  [WAYS*ENTRIES*WORDS];

   fc_pkg::fc_state_t state, next_state;
   logic [7:0]  ctrl, next_ctrl;
   logic        purgePend, next_purgePend;
   logic [5:0]  pIdx, next_pIdx;
   logic [31:0] aAddr, next_aAddr, aWdata, next_aWdata;
   logic [3:0]  aStrb, next_aStrb;
   logic        aWr, next_aWr, aFetch, next_aFetch;
   logic [1:0]  cnt, next_cnt, vWay, next_vWay;
   logic [TW-1:0] vTag, next_vTag;
   logic [31:0] next_prdata, next_cpuRdata, next_memAddr, next_memWdata;
   logic        next_pready, next_pslverr, next_cpuReady, next_memReq, next_memWr;
   logic [3:0]  next_memStrb;

   // Array write commands
   logic          metaWe, metaValid, metaDirty, lruWe, dataWe, purgeClr;
   logic [1:0]    metaWay;
   logic [TW-1:0] metaTag;
   logic [9:0]    dIdx;
   logic [31:0]   dVal;
   logic [3:0]    dMask;

   logic [2:0]    area;
   logic [5:0]    idx;
   logic [1:0]    word, hitWay;
   logic [TW-1:0] tag;
   logic          hit, apbWr, apbHit;

   fc_lru_if lruIf ();
   fc_plru uPlru (
      .lru (lruIf)
   );

   assign area = aAddr[31:29];
   assign idx  = aAddr[fc_pkg::IDX_LO +: 6];
   assign word = aAddr[3:2];
   assign tag  = aAddr[fc_pkg::TAG_LO +: TW];
   assign apbHit = (paddr == fc_pkg::CTRL_ADDR);
   assign apbWr  = psel && penable && pready && pwrite && apbHit;

   always_comb begin
      hit = 1'b0;
      hitWay = 2'h0;
      for (int w = 0; w < WAYS; w++) begin
         // ways 0 and 1 never hit while they serve as RAM
         if (validMem[w][idx] && tagMem[w][idx] == tag
             && !(ctrl[fc_pkg::CTRL_TWO_WAY] && w < 2)) begin
            hit = 1'b1;
            hitWay = 2'(w);
         end
      end
   end

   assign lruIf.lruState = lruMem[idx];
   assign lruIf.twoWay   = ctrl[fc_pkg::CTRL_TWO_WAY];
   assign lruIf.usedWay  = (state == fc_pkg::S_FILL) ? vWay : hitWay;

   // APB slave: no wait states, answer prepared in the setup cycle
   always_comb begin
      next_pready  = psel && !penable;
      next_pslverr = psel && !penable && !apbHit;
      next_prdata  = 32'h0;
      if (psel && !penable && apbHit && !pwrite) begin
         next_prdata[7:0] = ctrl;
         next_prdata[fc_pkg::CTRL_PURGE] = 1'b0;
      end
   end

   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_purgePend = purgePend;
      next_pIdx = pIdx;
      next_aAddr = aAddr;
      next_aWdata = aWdata;
      next_aStrb = aStrb;
      next_aWr = aWr;
      next_aFetch = aFetch;
      next_cnt = cnt;
      next_vWay = vWay;
      next_vTag = vTag;
      next_cpuRdata = cpuRdata;
      next_cpuReady = 1'b0;
      next_memReq = memReq;
      next_memWr = memWr;
      next_memAddr = memAddr;
      next_memWdata = memWdata;
      next_memStrb = memStrb;
      metaWe = 1'b0;
      metaWay = hitWay;
      metaTag = tag;
      metaValid = 1'b0;
      metaDirty = 1'b0;
      lruWe = 1'b0;
      dataWe = 1'b0;
      dIdx = {hitWay, idx, word};
      dVal = aWdata;
      dMask = aStrb;
      purgeClr = 1'b0;
      if (apbWr) begin
         next_ctrl = pwdata[7:0];
         next_ctrl[fc_pkg::CTRL_PURGE] = 1'b0;
      end
      case (state)
         fc_pkg::S_IDLE: begin
            if (purgePend) begin
               next_state = fc_pkg::S_PURGE;
               next_pIdx = 6'h0;
               next_purgePend = 1'b0;
            end else if (cpuReq && !cpuReady) begin
               next_aAddr = cpuAddr;
               next_aWdata = cpuWdata;
               next_aStrb = cpuStrb;
               next_aWr = cpuWr;
               next_aFetch = cpuFetch;
               next_state = fc_pkg::S_LOOK;
            end
         end
         fc_pkg::S_PURGE: begin
            // requests wait in IDLE until the walk ends
            purgeClr = 1'b1;
            next_pIdx = pIdx + 6'h1;
            if (pIdx == 6'(ENTRIES - 1))
               next_state = fc_pkg::S_IDLE;
         end
         fc_pkg::S_LOOK: begin
            next_state = fc_pkg::S_IDLE;
            next_cpuReady = 1'b1;
            case (area)
               fc_pkg::AREA_CACHED: begin
                  if (!ctrl[fc_pkg::CTRL_EN]) begin
                     next_cpuReady = 1'b0;
                     next_state = fc_pkg::S_THRU;
                  end else if (hit) begin
                     lruWe = 1'b1;
                     next_cpuRdata = dataMem[{hitWay, idx, word}];
                     if (aWr) begin
                        dataWe = 1'b1;
                        if (ctrl[fc_pkg::CTRL_WB]) begin
                           metaWe = 1'b1;
                           metaValid = 1'b1;
                           metaDirty = 1'b1;
                        end else begin
                           next_cpuReady = 1'b0;
                           next_state = fc_pkg::S_THRU;
                        end
                     end
                  end else begin
                     next_cpuReady = 1'b0;
                     // inhibits only seen here, with the cache enabled
                     if ((aWr && !ctrl[fc_pkg::CTRL_WB])
                         || (aFetch ? ctrl[fc_pkg::CTRL_I_INH] : ctrl[fc_pkg::CTRL_D_INH])) begin
                        next_state = fc_pkg::S_THRU;
                     end else begin
                        next_vWay = lruIf.victim;
                        next_vTag = tagMem[lruIf.victim][idx];
                        next_memReq = 1'b1;
                        next_memStrb = 4'hf;
                        if (validMem[lruIf.victim][idx] && dirtyMem[lruIf.victim][idx]) begin
                           next_state = fc_pkg::S_WBACK;
                           next_cnt = 2'h0;
                           next_memWr = 1'b1;
                           next_memAddr = {aAddr[31:29], tagMem[lruIf.victim][idx], idx, 4'h0};
                           next_memWdata = dataMem[{lruIf.victim, idx, 2'h0}];
                        end else begin
                           next_state = fc_pkg::S_FILL;
                           next_cnt = word + 2'h1;
                           next_memWr = 1'b0;
                           next_memAddr = {aAddr[31:4], word + 2'h1, 2'h0};
                        end
                     end
                  end
               end
               fc_pkg::AREA_APURGE: begin
                  metaWe = hit;
               end
               fc_pkg::AREA_ADDRARR: begin
                  metaWay = ctrl[fc_pkg::CTRL_WAY_LO +: 2];
                  metaWe = aWr;
                  metaTag = aWdata[fc_pkg::TAG_LO +: TW];
                  metaValid = aWdata[fc_pkg::AA_VALID];
                  metaDirty = aWdata[fc_pkg::AA_DIRTY];
                  next_cpuRdata = 32'h0;
                  next_cpuRdata[fc_pkg::TAG_LO +: TW] = tagMem[metaWay][idx];
                  next_cpuRdata[fc_pkg::AA_VALID] = validMem[metaWay][idx];
                  next_cpuRdata[fc_pkg::AA_DIRTY] = dirtyMem[metaWay][idx];
               end
               fc_pkg::AREA_DATAARR: begin
                  dIdx = {aAddr[fc_pkg::WAY_LO +: 2], idx, word};
                  dataWe = aWr;
                  next_cpuRdata = dataMem[dIdx];
               end
               default: begin
                  next_cpuReady = 1'b0;
                  next_state = fc_pkg::S_THRU;
               end
            endcase
            if (next_state == fc_pkg::S_THRU) begin
               next_memReq = 1'b1;
               next_memWr = aWr;
               next_memAddr = aAddr;
               next_memWdata = aWdata;
               next_memStrb = aStrb;
            end
         end
         fc_pkg::S_WBACK: begin
            if (memAck) begin
               next_cnt = cnt + 2'h1;
               next_memAddr = {aAddr[31:29], vTag, idx, cnt + 2'h1, 2'h0};
               next_memWdata = dataMem[{vWay, idx, cnt + 2'h1}];
               if (cnt == 2'(WORDS - 1)) begin
                  // Write-back finished before the fill: no line buffer needed
                  next_state = fc_pkg::S_FILL;
                  next_cnt = word + 2'h1;
                  next_memWr = 1'b0;
                  next_memAddr = {aAddr[31:4], word + 2'h1, 2'h0};
               end
            end
         end
         fc_pkg::S_FILL: begin
            if (memAck) begin
               dataWe = 1'b1;
               dIdx = {vWay, idx, cnt};
               dVal = memRdata;
               dMask = 4'hf;
               next_cnt = cnt + 2'h1;
               next_memAddr = {aAddr[31:4], cnt + 2'h1, 2'h0};
               if (cnt == word) begin
                  // Store data merges into the requested word as it lands
                  if (aWr) begin
                     for (int b = 0; b < 4; b++) begin
                        if (aStrb[b])
                           dVal[8*b +: 8] = aWdata[8*b +: 8];
                     end
                  end
                  metaWe = 1'b1;
                  metaWay = vWay;
                  metaValid = 1'b1;
                  metaDirty = aWr;
                  lruWe = 1'b1;
                  next_cpuRdata = memRdata;
                  next_cpuReady = 1'b1;
                  next_memReq = 1'b0;
                  next_state = fc_pkg::S_IDLE;
               end
            end
         end
         fc_pkg::S_THRU: begin
            if (memAck) begin
               next_memReq = 1'b0;
               next_cpuRdata = memRdata;
               next_cpuReady = 1'b1;
               next_state = fc_pkg::S_IDLE;
            end
         end
         default: next_state = fc_pkg::S_IDLE;
      endcase
      // Set wins over the clear taken in IDLE
      if (apbWr && pwdata[fc_pkg::CTRL_PURGE])
         next_purgePend = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= fc_pkg::S_IDLE;
         ctrl      <= fc_pkg::CTRL_RESET;
         purgePend <= 1'b0;
         pIdx      <= 6'h0;
         aAddr     <= 32'h0;
         aWdata    <= 32'h0;
         aStrb     <= 4'h0;
         aWr       <= 1'b0;
         aFetch    <= 1'b0;
         cnt       <= 2'h0;
         vWay      <= 2'h0;
         vTag      <= '0;
         prdata    <= 32'h0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         cpuRdata  <= 32'h0;
         cpuReady  <= 1'b0;
         memReq    <= 1'b0;
         memWr     <= 1'b0;
         memAddr   <= 32'h0;
         memWdata  <= 32'h0;
         memStrb   <= 4'h0;
      end else if (clkEn) begin
         state     <= next_state;
         ctrl      <= next_ctrl;
         purgePend <= next_purgePend;
         pIdx      <= next_pIdx;
         aAddr     <= next_aAddr;
         aWdata    <= next_aWdata;
         aStrb     <= next_aStrb;
         aWr       <= next_aWr;
         aFetch    <= next_aFetch;
         cnt       <= next_cnt;
         vWay      <= next_vWay;
         vTag      <= next_vTag;
         prdata    <= next_prdata;
         pready    <= next_pready;
         pslverr   <= next_pslverr;
         cpuRdata  <= next_cpuRdata;
         cpuReady  <= next_cpuReady;
         memReq    <= next_memReq;
         memWr     <= next_memWr;
         memAddr   <= next_memAddr;
         memWdata  <= next_memWdata;
         memStrb   <= next_memStrb;
      end
   end

   // Array storage: tag, valid, dirty and LRU contents are undefined until software purges; data is never cleared
   always_ff @(posedge mclk) begin
      if (clkEn) begin
         if (purgeClr) begin
            for (int w = 0; w < WAYS; w++) begin
               validMem[w][pIdx] <= 1'b0;
               dirtyMem[w][pIdx] <= 1'b0;
               tagMem[w][pIdx]   <= '0;
            end
            lruMem[pIdx] <= 3'h0;
         end
         if (metaWe) begin
            tagMem[metaWay][idx]   <= metaTag;
            validMem[metaWay][idx] <= metaValid;
            dirtyMem[metaWay][idx] <= metaDirty;
         end
         if (lruWe)
            lruMem[idx] <= lruIf.touched;
         if (dataWe) begin
            for (int b = 0; b < 4; b++) begin
               if (dMask[b])
                  dataMem[dIdx][8*b +: 8] <= dVal[8*b +: 8];
            end
         end
      end
   end
endmodule

// File: verif/fc_cache_ctrl_assertions.sv
// Port-level checks for the cache controller, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
module fc_cache_ctrl_assertions #(
   parameter int WAYS    = 4,
   parameter int ENTRIES = 64,
   parameter int WORDS   = 4
) (
   // Clock, reset and APB
   input wire logic        mclk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] paddr, pwdata, prdata,
   // CPU side, plus memStrb
   input wire logic        cpuReq, cpuWr, cpuFetch, cpuReady,
   input wire logic [31:0] cpuAddr, cpuWdata, cpuRdata,
   input wire logic [3:0]  cpuStrb, memStrb,
   // Memory side
   input wire logic        memReq, memWr, memAck,
   input wire logic [31:0] memAddr, memWdata, memRdata
);
   logic [7:0]  shadow;
   logic [31:0] ackAddr;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Software view of the control byte; the purge bit never sticks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) shadow <= 8'h00;
      else if (psel && penable && pready && pwrite && !pslverr) shadow <= pwdata[7:0] & 8'hef;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) ackAddr <= 32'h0;
      else if (memAck) ackAddr <= memAddr;
   end
   chk_apb_answer: assert property (psel && !penable && clkEn |=> pready)
      else $error("pready missing after setup");
   chk_apb_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_ctrl_value: assert property (pready && !pwrite && !pslverr |-> prdata == {24'h0, shadow})
      else $error("control read differs from written value");
   chk_purge_reads0: assert property (pready && !pwrite |-> !prdata[fc_pkg::CTRL_PURGE])
      else $error("purge bit read as one");
   chk_apb_err: assert property (pready |-> pslverr == (paddr != fc_pkg::CTRL_ADDR))
      else $error("slave error does not match address");
   chk_cpu_pulse: assert property (cpuReady |=> !cpuReady)
      else $error("cpu ready held too long");
   chk_cpu_cause: assert property (cpuReady |-> $past(cpuReq) && !memReq)
      else $error("cpu answered without request or during memory cycle");
   chk_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
      && $stable(memWr) && $stable(memWdata))
      else $error("memory request changed before ack");
   chk_fill_stride: assert property (memAck && !memWr ##1 memReq && !memWr
      |-> memAddr == {ackAddr[31:4], ackAddr[3:2] + 2'h1, 2'h0})
      else $error("refill word order broken");
   cover property (pready && pslverr);
   cover property (memAck && memWr);
   cover property (memAck && !memWr ##1 memReq && !memWr);
endmodule

bind fc_cache_ctrl fc_cache_ctrl_assertions #(.WAYS(WAYS), .ENTRIES(ENTRIES), .WORDS(WORDS))
   chkU (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuFetch(cpuFetch), .cpuReady(cpuReady),
   .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuStrb(cpuStrb),
   .memStrb(memStrb), .memReq(memReq), .memWr(memWr), .memAck(memAck), .memAddr(memAddr),
   .memWdata(memWdata), .memRdata(memRdata));

// File: verif/fc_mem_model.sv
// Behavioural external memory on the controller's internal bus.
// Assumes requests are held until acked; one word per ack pulse.
module fc_mem_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Idle cycles before each ack
   input  wire logic [3:0]  waitCycles,
   // Bus from the controller
   input  wire logic        memReq,
   input  wire logic [31:0] memAddr,
   output logic      [31:0] memRdata,
   output logic             memAck
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] waitCnt;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt  <= 4'h0;
         memAck   <= 1'h0;
         memRdata <= 32'h0;
      end else if (memReq && !memAck && waitCnt == waitCycles) begin
         waitCnt  <= 4'h0;
         memAck   <= 1'h1;
         memRdata <= {memAddr[15:0], ~memAddr[15:0]};
      end else begin
         waitCnt  <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
         memAck   <= 1'h0;
         // Data is only valid with the ack, so it toggles otherwise
         memRdata <= ~memRdata;
      end
   end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the four-way cache controller.
// Assumes fc_mem_model as external memory and the bound port checker.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] LA = 32'h00000108;
   localparam logic [31:0] TS = 32'h00000400;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        cpuReq, cpuWr, cpuFetch, cpuReady, memReq, memWr, memAck;
   logic [31:0] paddr, pwdata, prdata, cpuAddr, cpuWdata, cpuRdata, rd, word;
   logic [31:0] memAddr, memWdata, memRdata;
   logic [3:0]  cpuStrb, memStrb, waitCycles, mask;
   logic [31:0] memLog[$];
   int          memWrites, miscompares, numChecks, lat;

   fc_cache_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .clkEn(1'h1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuFetch(cpuFetch),
      .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuStrb(cpuStrb), .cpuRdata(cpuRdata),
      .cpuReady(cpuReady), .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
      .memWdata(memWdata), .memStrb(memStrb), .memRdata(memRdata), .memAck(memAck));
   fc_mem_model mem_u (.mclk(mclk), .rst_n(rst_n), .waitCycles(waitCycles), .memReq(memReq),
      .memAddr(memAddr), .memRdata(memRdata), .memAck(memAck));

   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (memAck === 1'h1) begin
         memLog.push_back(memAddr);
         if (memWr === 1'h1) memWrites++;
      end
   end

   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction
   task automatic stopTest();
      if (miscompares == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      // Answer is taken at the same rising edge that shows pready high
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) chk("apb wait", 32'h1, 32'h0);
      if (n >= 50) stopTest();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic cpuOp(input logic wr, input logic f, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      memLog.delete();
      memWrites = 0;
      cpuReq <= 1'h1;
      cpuWr <= wr;
      cpuFetch <= f;
      cpuAddr <= a;
      cpuWdata <= d;
      lat = 0;
      do begin
         @(posedge mclk);
         lat++;
      end while (cpuReady !== 1'h1 && lat < 400);
      if (lat >= 400) chk("cpu wait", 32'h1, 32'h0);
      if (lat >= 400) stopTest();
      rd = cpuRdata;
      cpuReq <= 1'h0;
   endtask
   task automatic nMem(input string name, input int n);
      chk(name, 32'(n), 32'(memLog.size()));
   endtask
   task automatic checkFill(input logic [31:0] a);
      logic [1:0] w;
      nMem("fill count", 4);
      for (int i = 0; i < 4 && i < memLog.size(); i++) begin
         w = a[3:2] + 2'(i + 1);
         chk("fill addr", {a[31:4], w, 2'h0}, memLog[i]);
      end
   endtask
   // Scans the four ways through the address array for a valid matching tag
   task automatic waysHolding(input logic [31:0] a, input logic [5:0] low);
      mask = 4'h0;
      for (int w = 0; w < 4; w++) begin
         apb(1'h1, fc_pkg::CTRL_ADDR, {24'h0, 2'(w), low});
         cpuOp(1'h0, 1'h0, {3'h3, 19'h0, a[9:4], 4'h0}, 32'h0);
         if (rd[fc_pkg::AA_VALID] === 1'h1 && rd[28:10] === a[28:10]) begin
            mask[w] = 1'h1;
            word = rd;
         end
      end
   endtask

   initial begin
      rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 32'h0; pwdata = 32'h0;
      cpuReq = 1'h0; cpuWr = 1'h0; cpuFetch = 1'h0; cpuAddr = 32'h0; cpuWdata = 32'h0;
      cpuStrb = 4'hf; waitCycles = 4'h0; miscompares = 0; numChecks = 0; memWrites = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'h1;
      apb(1'h0, fc_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'hff);
      apb(1'h0, fc_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl readback", 32'hef, rd);
      apb(1'h0, 32'h00000010, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h10);
      cpuOp(1'h0, 1'h0, 32'h20000108, 32'h0);
      chk("purge stall", 32'h1, {31'h0, lat > 40});
      nMem("through reads", 1);
      chk("through data", pat(32'h20000108), rd);
      apb(1'h0, fc_pkg::CTRL_ADDR, 32'h0);
      chk("purge self clear", 32'h0, rd);
      cpuOp(1'h0, 1'h0, LA, 32'h0);
      nMem("disabled reads", 1);
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h01);
      cpuOp(1'h0, 1'h0, LA, 32'h0);
      checkFill(LA);
      chk("miss data", pat(LA), rd);
      cpuOp(1'h0, 1'h0, LA, 32'h0);
      nMem("hit reads", 0);
      chk("hit latency", 32'h3, 32'(lat));
      waysHolding(LA, 6'h01);
      chk("ways holding line", 32'h1, 32'($countones(mask)));
      for (int k = 1; k < 4; k++) cpuOp(1'h0, 1'h0, LA + 32'(k) * TS, 32'h0);
      nMem("fourth tag fill", 4);
      cpuOp(1'h0, 1'h0, LA + 4 * TS, 32'h0);
      cpuOp(1'h0, 1'h0, LA + 3 * TS, 32'h0);
      nMem("recent line kept", 0);
      cpuOp(1'h1, 1'h0, LA + 3 * TS, 32'hcafe0001);
      chk("write through", 32'h1, 32'(memWrites));
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h21);
      cpuOp(1'h1, 1'h0, LA + 4 * TS, 32'h5eed0002);
      nMem("write back hit", 0);
      chk("write back latency", 32'h3, 32'(lat));
      waysHolding(LA + 4 * TS, 6'h21);
      chk("dirty bit", 32'h1, {31'h0, word[fc_pkg::AA_DIRTY]});
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h05);
      waitCycles <= 4'h2;
      for (int k = 0; k < 2; k++) cpuOp(1'h0, 1'h0, LA + 5 * TS, 32'h0);
      nMem("data inhibit miss", 1);
      cpuOp(1'h0, 1'h0, LA + 3 * TS, 32'h0);
      chk("data inhibit hit", 32'hcafe0001, rd);
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h03);
      cpuOp(1'h0, 1'h1, LA + 6 * TS, 32'h0);
      nMem("fetch inhibit miss", 1);
      cpuOp(1'h0, 1'h0, LA + 6 * TS, 32'h0);
      checkFill(LA + 6 * TS);
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h10);
      apb(1'h1, fc_pkg::CTRL_ADDR, 32'h09);
      cpuOp(1'h1, 1'h0, 32'hc0000108, 32'h1234abcd);
      cpuOp(1'h0, 1'h0, LA + 7 * TS, 32'h0);
      checkFill(LA + 7 * TS);
      waysHolding(LA + 7 * TS, 6'h09);
      chk("two-way fill way", 32'h1, {31'h0, mask == 4'h4 || mask == 4'h8});
      cpuOp(1'h0, 1'h0, 32'hc0000108, 32'h0);
      chk("ram word", 32'h1234abcd, rd);
      cpuOp(1'h0, 1'h0, 32'h40000000 | (LA + 7 * TS), 32'h0);
      cpuOp(1'h0, 1'h0, LA + 7 * TS, 32'h0);
      nMem("assoc purge refill", 4);
      // Manual reset in mid-run must clear the control byte again
      rst_n <= 1'h0;
      @(posedge mclk);
      rst_n <= 1'h1;
      apb(1'h0, fc_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl manual reset", 32'h0, rd);
      stopTest();
   end
   initial begin
      repeat (100000) @(posedge mclk);
      chk("run length", 32'h1, 32'h0);
      stopTest();
   end
endmodule
